// file: smm_link_sync.sv
// serial memory master: shared package and the two-flop synchroniser.
// assumes the importing logic runs on clk (core) and link_clk (link).
package smm_pkg;

	//////////////////////////////////////////////////////////////////
	// link timing: the link clock runs at 32 ns
	localparam int LINK_PERIOD_PS = 32000;
	localparam int I2C_STD_KHZ    = 100;  // standard mode ceiling
	localparam int I2C_FAST_KHZ   = 400;  // fast mode ceiling
	// quarter scl period in link cycles, rounded up so the rate never exceeds the ceiling
	localparam int I2C_STD_QTR  = (1000000000 / (4 * I2C_STD_KHZ) + LINK_PERIOD_PS - 1)
		/ LINK_PERIOD_PS;
	localparam int I2C_FAST_QTR = (1000000000 / (4 * I2C_FAST_KHZ) + LINK_PERIOD_PS - 1)
		/ LINK_PERIOD_PS;
	localparam logic [7:0] I2C_STD_LIM  = 8'(I2C_STD_QTR - 1);
	localparam logic [7:0] I2C_FAST_LIM = 8'(I2C_FAST_QTR - 1);

	//////////////////////////////////////////////////////////////////
	// field widths and bit positions
	localparam int         CNT_W        = 16;     // byte count width
	localparam int         ADDR_W       = 24;     // widest spi address
	localparam logic [4:0] SPI_BYTE_TOP = 5'h07;  // top bit of a data byte
	localparam logic [4:0] I2C_BYTE_TOP = 5'h08;  // 8 data slots then ack slot
	localparam logic [4:0] ACK_SLOT     = 5'h00;  // last slot of an i2c byte
	localparam logic [1:0] SPI_PH_LAST  = 2'h1;   // two halves per spi bit
	localparam logic [1:0] I2C_PH_LAST  = 2'h3;   // four quarters per i2c bit
	localparam logic [1:0] I2C_SAMP_PH  = 2'h1;   // sda sampled mid scl high
	localparam logic [CNT_W-1:0] LAST_BYTE = 16'h0001;
	localparam logic [CNT_W-1:0] NO_BYTES  = 16'h0000;

	//////////////////////////////////////////////////////////////////
	// one transfer request, held stable by the core while the link runs
	typedef struct packed {
		logic              i2c_mode;              // 1: i2c frame, 0: spi frame
		logic              rw_read;               // 1: read, 0: write/program
		logic              cpol;                  // spi idle clock level
		logic              cpha;                  // spi sample on trailing edge
		logic              lsb_first;             // spi bit order
		logic              cs_sel;                // which chip select
		logic [1:0]        cs_pol;                // per select: 1 active high
		logic [2:0]        command_code_top_bit;  // cmd / codec header length - 1
		logic              has_addr;              // spi address phase present
		logic [4:0]        address_top_bit;       // address length - 1
		logic [7:0]        cmd;                   // command code or codec_header_bits
		logic [ADDR_W-1:0] addr;                  // spi memory address
		logic [7:0]        spi_div;               // spi half period - 1, link cycles
		logic              i2c_fast;              // 400 kHz ceiling instead of 100
		logic              scl_push_pull;         // scl as cmos output
		logic [6:0]        slave_id_bits;         // 7-bit i2c device address
		logic [7:0]        start_byte_offset_bits;// first byte address
		logic [CNT_W-1:0]  byte_cnt;              // data bytes to move
	} smm_req_s;

	// link state machine
	typedef enum logic [3:0] {
		ST_IDLE, ST_SP_CMD, ST_SP_ADDR, ST_SP_DATA, ST_WAIT_TX,
		ST_SP_GAP, ST_I_START, ST_I_BIT, ST_I_STOP, ST_FIN
	} smm_state_e;

	// what the current i2c byte carries
	typedef enum logic [2:0] {IB_DEVW, IB_OFS, IB_DEVR, IB_WR, IB_RD} smm_ibyte_e;

endpackage : smm_pkg

`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////
// two flops per bit; the first is read by the second only
module smm_sync2 #(
	parameter int W = 1
) (
	// destination clock
	input  wire logic         clk,
	// asynchronous level in, synchronised level out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] sync_q
);
	logic [W-1:0] meta_q;  // metastability catcher

	// no reset: the chain also carries the reset into the link domain
	always_ff @(posedge clk) begin
		meta_q <= d;
		sync_q <= meta_q;
	end
endmodule : smm_sync2

// file: smm_serial_memory_master.sv
// serial memory master: spi or i2c frames towards eeprom, flash or codec.
// assumes a core clock at 25 MHz and a free-running link clock at 32 ns.
// Summary of operation
// - only one frame format active at once
// - spi sends command code, then address
// - command and address lengths are configurable
// - chip select held until read count reached
// - chip select held until write count sent
// - codec gets 8-bit header before data
// - one codec header may precede many bytes
// - every i2c transaction opens with start
// - 7-bit slave id plus direction bit
// - 8-bit start byte offset follows
// - i2c bytes go most significant bit first
// - ack driven after each byte read except the last
// - last read byte answered with nack
// - multi-byte transfer without start between bytes
// - stop only after all bytes moved or a written byte refused
// - scl at most 100 or 400 kHz
// - two chip selects, polarity selectable each
// - all four cpol/cpha combinations supported
// - spi bit order msb or lsb first
// - scl open drain or push pull
`timescale 1ns/1ps

module smm_serial_memory_master (
	// core clock domain
	input  wire logic             clk,
	input  wire logic             rst,
	// link clock domain
	input  wire logic             link_clk,
	// transfer request
	input  wire logic             start,
	input  wire smm_pkg::smm_req_s req,
	output logic                  busy_q,
	output logic                  done_q,
	output logic                  nack_q,
	// write byte stream
	input  wire logic [7:0]       tx_data,
	input  wire logic             tx_valid,
	output logic                  tx_ready_q,
	// read byte stream
	output logic [7:0]            rx_data_q,
	output logic                  rx_valid_q,
	// spi pins
	output logic                  spi_sclk_q,
	output logic                  spi_mosi_q,
	output logic [1:0]            spi_cs_q,
	input  wire logic             spi_miso,
	// i2c pins
	output logic                  i2c_scl_o_q,
	output logic                  i2c_scl_oe_q,
	input  wire logic             i2c_sda_i,
	output logic                  i2c_sda_o_q,
	output logic                  i2c_sda_oe_q
);
	//////////////////////////////////////////////////////////////////
	// crossings
	smm_pkg::smm_req_s req_q;         // request held for the link
	logic              req_tgl_q;     // core -> link: new request
	logic              tx_tgl_q;      // core -> link: tx byte waiting
	logic [7:0]        tx_buf_q;      // the waiting tx byte
	logic              tx_seen_q;     // link -> core: tx byte taken
	logic              rx_tgl_q;      // link -> core: rx byte ready
	logic [7:0]        rx_hold_q;     // the ready rx byte
	logic              done_tgl_q;    // link -> core: transfer over
	logic              ack_nak_q;     // link: a written byte got nack
	logic              done_s, txack_s, rx_s, lrst, req_s, tx_s, miso_s, sda_s;

	smm_sync2 #(.W(3)) u_core_sync (
		.clk    (clk),
		.d      ({done_tgl_q, tx_seen_q, rx_tgl_q}),
		.sync_q ({done_s, txack_s, rx_s})
	);
	smm_sync2 #(.W(5)) u_link_sync (
		.clk    (link_clk),
		.d      ({rst, req_tgl_q, tx_tgl_q, spi_miso, i2c_sda_i}),
		.sync_q ({lrst, req_s, tx_s, miso_s, sda_s})
	);

	//////////////////////////////////////////////////////////////////
	// core side: request, byte streams and completion
	logic done_seen_q, rx_seen_q;
	wire  launch   = start && !busy_q;            // requests while busy are dropped
	wire  tx_take  = tx_valid && tx_ready_q;
	wire  tx_tgl_d = tx_tgl_q ^ tx_take;
	wire  done_ev  = done_s != done_seen_q;
	wire  rx_ev    = rx_s != rx_seen_q;

	// one byte in flight; ready returns only when the link has taken it
	always_ff @(posedge clk) begin
		if (rst) begin
			req_q <= '0; req_tgl_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b0;
			nack_q <= 1'b0; tx_tgl_q <= 1'b0; tx_buf_q <= 8'h00; tx_ready_q <= 1'b1;
			rx_data_q <= 8'h00; rx_valid_q <= 1'b0; done_seen_q <= 1'b0; rx_seen_q <= 1'b0;
		end else begin
			done_seen_q <= done_s;
			rx_seen_q   <= rx_s;
			done_q      <= done_ev;
			rx_valid_q  <= rx_ev;
			busy_q      <= launch || (busy_q && !done_ev);
			tx_tgl_q    <= tx_tgl_d;
			tx_ready_q  <= !(tx_tgl_d ^ txack_s);
			if (launch) begin
				req_q     <= req;
				req_tgl_q <= !req_tgl_q;
			end
			if (tx_take) tx_buf_q <= tx_data;
			if (rx_ev) rx_data_q <= rx_hold_q;     // hold is stable once toggle seen
			if (done_ev) nack_q <= ack_nak_q;
		end
	end

	//////////////////////////////////////////////////////////////////
	// link side: timing
	smm_pkg::smm_req_s  lcfg_q;               // captured at launch
	smm_pkg::smm_state_e state_q, state_d;
	smm_pkg::smm_ibyte_e ib_q, ib_d;
	logic [7:0]         tick_q;                // divider count
	logic [1:0]         ph_q;                  // half or quarter of a bit
	logic [4:0]         bit_q, bit_d;          // bit slot, counts down
	logic [smm_pkg::CNT_W-1:0] bytes_q, bytes_d;  // data bytes left
	logic [7:0]         dbyte_q;               // current write byte
	logic [7:0]         rx_sh_q;               // read byte assembly
	logic               req_seen_q;
	logic               rx_push, tx_pop, fin;

	wire i2c      = lcfg_q.i2c_mode;
	wire tick_lim_sel = lcfg_q.i2c_fast;
	// divider limit per mode: spi_div half periods for spi, i2c quarter periods rounded to the rate ceiling
	wire [7:0] tick_lim = !i2c ? lcfg_q.spi_div
		: tick_lim_sel ? smm_pkg::I2C_FAST_LIM : smm_pkg::I2C_STD_LIM;
	wire [1:0] ph_last   = i2c ? smm_pkg::I2C_PH_LAST : smm_pkg::SPI_PH_LAST;
	wire       tick_end  = tick_q == tick_lim;
	wire       slot_end  = tick_end && ph_q == ph_last;
	wire       field_end = slot_end && bit_q == smm_pkg::ACK_SLOT;
	wire       lstart    = req_s != req_seen_q;
	wire       tx_avail  = tx_s != tx_seen_q;
	wire       in_spi    = state_q inside {smm_pkg::ST_SP_CMD, smm_pkg::ST_SP_ADDR,
		smm_pkg::ST_SP_DATA};

	//////////////////////////////////////////////////////////////////
	// bit selection
	wire [4:0] spi_top = (state_q == smm_pkg::ST_SP_CMD) ? {2'b00, lcfg_q.command_code_top_bit}
		: (state_q == smm_pkg::ST_SP_ADDR) ? lcfg_q.address_top_bit : smm_pkg::SPI_BYTE_TOP;
	// a codec header rides the command field as its first eight bits
	wire [31:0] spi_word = (state_q == smm_pkg::ST_SP_CMD) ? {24'h000000, lcfg_q.cmd}
		: (state_q == smm_pkg::ST_SP_ADDR) ? {8'h00, lcfg_q.addr} : {24'h000000, dbyte_q};
	// lsb first walks the same field from the other end
	wire [4:0] spi_pos = lcfg_q.lsb_first ? 5'(spi_top - bit_q) : bit_q;
	wire       spi_bit = spi_word[spi_pos];
	wire [7:0] i2c_byte = (ib_q == smm_pkg::IB_DEVW) ? {lcfg_q.slave_id_bits, 1'b0}
		: (ib_q == smm_pkg::IB_OFS) ? lcfg_q.start_byte_offset_bits
		: (ib_q == smm_pkg::IB_DEVR) ? {lcfg_q.slave_id_bits, 1'b1} : dbyte_q;
	wire       sending  = ib_q != smm_pkg::IB_RD;
	wire       ack_slot = bit_q == smm_pkg::ACK_SLOT;
	wire       i2c_txb  = i2c_byte[3'(bit_q - 5'h01)];  // slots 8..1, msb first
	wire       last_rd  = bytes_q == smm_pkg::LAST_BYTE;
	// read: release for data, ack or final nack in the ack slot
	wire       i2c_dat  = sending ? (ack_slot || i2c_txb) : (!ack_slot || last_rd);
	wire       mid_q    = ph_q == 2'h1 || ph_q == 2'h2;   // scl high quarters

	// bus levels before the pin flops; data only moves while scl is low
	logic scl_lvl, sda_lvl;
	always_comb begin
		scl_lvl = 1'b1;
		sda_lvl = 1'b1;
		case (state_q)
			smm_pkg::ST_I_START: begin               // sda falls while scl high
				scl_lvl = mid_q;
				sda_lvl = !ph_q[1];
			end
			smm_pkg::ST_I_BIT: begin
				scl_lvl = mid_q;
				sda_lvl = i2c_dat;
			end
			smm_pkg::ST_I_STOP: begin                // sda rises while scl high
				scl_lvl = ph_q != 2'h0;
				sda_lvl = ph_q[1];
			end
			smm_pkg::ST_WAIT_TX: scl_lvl = !i2c;     // i2c waits with scl low
			default: ;
		endcase
	end

	// sample point: mid scl high for i2c, the phase-selected edge for spi
	wire samp    = tick_end && ph_q == (i2c ? smm_pkg::I2C_SAMP_PH : {1'b0, lcfg_q.cpha});
	wire rx_bit  = i2c ? sda_s : miso_s;           // spi memory drives miso
	wire [7:0] rx_next = (i2c || !lcfg_q.lsb_first) ? {rx_sh_q[6:0], rx_bit}
		: {rx_bit, rx_sh_q[7:1]};
	// bytes left after the current data byte
	wire [smm_pkg::CNT_W-1:0] left = (state_q == smm_pkg::ST_SP_DATA)
		? bytes_q - smm_pkg::LAST_BYTE : bytes_q;

	//////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_d = state_q;
		bit_d   = bit_q;
		ib_d    = ib_q;
		bytes_d = bytes_q;
		rx_push = 1'b0;
		tx_pop  = 1'b0;
		fin     = 1'b0;
		case (state_q)
			smm_pkg::ST_IDLE: if (lstart) begin      // one format per launch
				state_d = req_q.i2c_mode ? smm_pkg::ST_I_START : smm_pkg::ST_SP_CMD;
				bit_d   = {2'b00, req_q.command_code_top_bit};
				ib_d    = smm_pkg::IB_DEVW;
				bytes_d = req_q.byte_cnt;
			end
			smm_pkg::ST_SP_CMD, smm_pkg::ST_SP_ADDR, smm_pkg::ST_SP_DATA: begin
				if (!field_end) begin
					if (slot_end) bit_d = bit_q - 5'h01;
				end else begin
					bytes_d = left;
					rx_push = state_q == smm_pkg::ST_SP_DATA && lcfg_q.rw_read;
					if (state_q == smm_pkg::ST_SP_CMD && lcfg_q.has_addr) begin
						state_d = smm_pkg::ST_SP_ADDR;      // address right after code
						bit_d   = lcfg_q.address_top_bit;
					end else if (left == smm_pkg::NO_BYTES) begin
						state_d = smm_pkg::ST_SP_GAP;        // count reached
					end else if (lcfg_q.rw_read) begin
						state_d = smm_pkg::ST_SP_DATA;
						bit_d   = smm_pkg::SPI_BYTE_TOP;
					end else begin
						state_d = smm_pkg::ST_WAIT_TX;       // codec bytes follow header
					end
				end
			end
			smm_pkg::ST_WAIT_TX: if (tx_avail) begin
				tx_pop  = 1'b1;
				state_d = i2c ? smm_pkg::ST_I_BIT : smm_pkg::ST_SP_DATA;
				bit_d   = i2c ? smm_pkg::I2C_BYTE_TOP : smm_pkg::SPI_BYTE_TOP;
			end
			smm_pkg::ST_SP_GAP: if (tick_end) state_d = smm_pkg::ST_FIN;  // select off
			smm_pkg::ST_I_START: if (slot_end) begin
				state_d = smm_pkg::ST_I_BIT;
				bit_d   = smm_pkg::I2C_BYTE_TOP;
			end
			smm_pkg::ST_I_BIT: if (slot_end) begin
				bit_d = smm_pkg::I2C_BYTE_TOP;
				if (!ack_slot) begin
					bit_d = bit_q - 5'h01;
				end else if (sending && ack_nak_q) begin
					state_d = smm_pkg::ST_I_STOP;          // refused byte ends the frame
				end else begin
					case (ib_q)
						smm_pkg::IB_DEVW: ib_d = smm_pkg::IB_OFS;
						smm_pkg::IB_OFS: if (bytes_q == smm_pkg::NO_BYTES) begin
							state_d = smm_pkg::ST_I_STOP;
						end else if (lcfg_q.rw_read) begin
							ib_d    = smm_pkg::IB_DEVR;       // restart to turn direction
							state_d = smm_pkg::ST_I_START;
						end else begin
							ib_d    = smm_pkg::IB_WR;
							state_d = smm_pkg::ST_WAIT_TX;
						end
						smm_pkg::IB_DEVR: ib_d = smm_pkg::IB_RD;
						default: begin                    // data byte, no start between
							bytes_d = bytes_q - smm_pkg::LAST_BYTE;
							rx_push = !sending;
							if (last_rd) state_d = smm_pkg::ST_I_STOP;
							else if (sending) state_d = smm_pkg::ST_WAIT_TX;
						end
					endcase
				end
			end
			smm_pkg::ST_I_STOP: if (slot_end) state_d = smm_pkg::ST_FIN;
			smm_pkg::ST_FIN: begin
				fin     = 1'b1;
				state_d = smm_pkg::ST_IDLE;
			end
			default: state_d = smm_pkg::ST_IDLE;
		endcase
	end

	//////////////////////////////////////////////////////////////////
	// link sequencing registers
	wire hold_tick = state_q == smm_pkg::ST_IDLE || state_q == smm_pkg::ST_WAIT_TX;
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			state_q <= smm_pkg::ST_IDLE; ib_q <= smm_pkg::IB_DEVW; lcfg_q <= '0;
			tick_q <= 8'h00; ph_q <= 2'h0; bit_q <= 5'h00; bytes_q <= '0;
			req_seen_q <= 1'b0; tx_seen_q <= 1'b0; dbyte_q <= 8'h00;
		end else begin
			state_q <= state_d;
			ib_q    <= ib_d;
			bit_q   <= bit_d;
			bytes_q <= bytes_d;
			tick_q  <= (tick_end || hold_tick) ? 8'h00 : tick_q + 8'h01;
			ph_q    <= hold_tick ? 2'h0 : !tick_end ? ph_q
				: (ph_q == ph_last) ? 2'h0 : ph_q + 2'h1;
			if (state_q == smm_pkg::ST_IDLE && lstart) begin
				lcfg_q     <= req_q;
				req_seen_q <= req_s;
			end
			if (tx_pop) begin
				dbyte_q   <= tx_buf_q;
				tx_seen_q <= tx_s;
			end
		end
	end

	// read path, ack sampling and completion toggles
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			rx_sh_q <= 8'h00; rx_hold_q <= 8'h00; rx_tgl_q <= 1'b0;
			done_tgl_q <= 1'b0; ack_nak_q <= 1'b0;
		end else begin
			if (samp && !(i2c && ack_slot)) rx_sh_q <= rx_next;
			if (samp && i2c && ack_slot && sending && state_q == smm_pkg::ST_I_BIT)
				ack_nak_q <= sda_s;                   // memory answer
			else if (state_q == smm_pkg::ST_IDLE && lstart)
				ack_nak_q <= 1'b0;
			if (rx_push) begin
				// trailing-phase spi samples its last bit on the closing edge itself
				rx_hold_q <= samp ? rx_next : rx_sh_q;
				rx_tgl_q  <= !rx_tgl_q;
			end
			if (fin) done_tgl_q <= !done_tgl_q;
		end
	end

	//////////////////////////////////////////////////////////////////
	// pin flops
	wire       cs_act = !i2c && (in_spi || state_q == smm_pkg::ST_WAIT_TX);
	wire [1:0] cs_lvl;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cs
			// per select polarity
			assign cs_lvl[gi] = (cs_act && lcfg_q.cs_sel == 1'(gi)) ?
				lcfg_q.cs_pol[gi] : !lcfg_q.cs_pol[gi];
		end
	endgenerate

	// the pins lag the sequencer by one link cycle, uniformly
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			spi_cs_q <= 2'h3; spi_sclk_q <= 1'b0; spi_mosi_q <= 1'b0;
			i2c_scl_o_q <= 1'b0; i2c_scl_oe_q <= 1'b0;
			i2c_sda_o_q <= 1'b0; i2c_sda_oe_q <= 1'b0;
		end else begin
			spi_cs_q     <= cs_lvl;
			spi_sclk_q   <= lcfg_q.cpol ^ (in_spi && ph_q[0]);
			if (in_spi && !(lcfg_q.cpha && !ph_q[0])) spi_mosi_q <= spi_bit;
			i2c_scl_o_q  <= i2c && lcfg_q.scl_push_pull && scl_lvl;
			i2c_scl_oe_q <= i2c && (lcfg_q.scl_push_pull || !scl_lvl);
			i2c_sda_o_q  <= 1'b0;                   // sda only ever pulled low
			i2c_sda_oe_q <= i2c && !sda_lvl;
		end
	end

	//////////////////////////////////////////////////////////////////
	// checks
	chk_cmd_then_addr: assert property (@(posedge link_clk) disable iff (lrst)
		state_q == smm_pkg::ST_SP_CMD && field_end && lcfg_q.has_addr
		|=> state_q == smm_pkg::ST_SP_ADDR) else $error("address did not follow command");
	chk_cs_held: assert property (@(posedge link_clk) disable iff (lrst)
		cs_act |=> spi_cs_q[lcfg_q.cs_sel] == lcfg_q.cs_pol[lcfg_q.cs_sel])
		else $error("chip select dropped inside transfer");
	chk_cs_release: assert property (@(posedge link_clk) disable iff (lrst)
		state_q == smm_pkg::ST_SP_GAP |=> spi_cs_q == ~lcfg_q.cs_pol)
		else $error("chip select not released after last byte");
	chk_one_format: assert property (@(posedge link_clk) disable iff (lrst)
		i2c && state_q != smm_pkg::ST_IDLE |=> spi_cs_q == ~lcfg_q.cs_pol && !spi_sclk_q
		== !lcfg_q.cpol) else $error("spi active during i2c frame");
	chk_i2c_start: assert property (@(posedge link_clk) disable iff (lrst)
		state_q == smm_pkg::ST_IDLE && lstart && req_q.i2c_mode
		|=> state_q == smm_pkg::ST_I_START ##1 i2c_scl_oe_q) else $error("no start generated");
	chk_ack_reads: assert property (@(posedge link_clk) disable iff (lrst)
		state_q == smm_pkg::ST_I_BIT && !sending && ack_slot && !last_rd
		|=> i2c_sda_oe_q) else $error("read byte not acknowledged");
	chk_last_nack: assert property (@(posedge link_clk) disable iff (lrst)
		state_q == smm_pkg::ST_I_BIT && !sending && ack_slot && last_rd
		|=> !i2c_sda_oe_q) else $error("last read byte not answered with nack");
	chk_stop_at_end: assert property (@(posedge link_clk) disable iff (lrst)
		$rose(state_q == smm_pkg::ST_I_STOP) && !ack_nak_q
		|-> bytes_q == smm_pkg::NO_BYTES || ib_q == smm_pkg::IB_OFS) else $error("early stop");
	chk_scl_rate: assert property (@(posedge link_clk) disable iff (lrst)
		$rose(i2c_scl_oe_q) && !lcfg_q.scl_push_pull |-> i2c_scl_oe_q [*8])
		else $error("scl low phase too short");
	cov_spi_read: cover property (@(posedge link_clk) disable iff (lrst)
		state_q == smm_pkg::ST_SP_DATA && rx_push && !i2c);
	cov_i2c_restart: cover property (@(posedge link_clk) disable iff (lrst)
		state_q == smm_pkg::ST_I_START && ib_q == smm_pkg::IB_DEVR);
	cov_i2c_nack: cover property (@(posedge link_clk) disable iff (lrst) ack_nak_q && fin);
	cov_spi_write: cover property (@(posedge link_clk) disable iff (lrst) tx_pop && !i2c);
endmodule : smm_serial_memory_master

// file: smm_mem_model.sv
// far-side model: spi memory with one stored byte, i2c memory that acks and reads.
// assumes spi mode 0 on low-active spi_cs_q[0]; sda is wired-and in the bench
`timescale 1ns/1ps

module smm_mem_model (
	// spi side
	input  wire logic sclk,
	input  wire logic cs_n,
	output logic      miso,
	// i2c side
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic nack_all,
	output logic      sda_pull
);
	localparam logic [7:0] STORED = 8'hA5;  // byte held at every address
	int edge_n = 0;          // sclk rises since select
	int bit_n  = 0;          // i2c bits done in this byte
	int byte_n = 0;          // i2c bytes since start
	logic [7:0] sh = 8'h00;  // i2c bits seen in this byte
	logic rd = 1'b0;         // addressed for reading
	initial sda_pull = 1'b0;
	initial miso = 1'b0;
	//////////////////////////////////////////////////////////////////
	// stored bit msb first; unselected shows the inverse, never a stale bit
	always @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			edge_n = 0;
			miso = ~miso;
		end else begin
			edge_n++;
			miso = STORED[7 - edge_n % 8];
		end
	end
	// start or stop: next scl fall closes the condition, not a bit
	always @(sda) begin
		if (scl === 1'b1) begin
			bit_n = -1;
			byte_n = 0;
			rd = 1'b0;
		end
	end
	// a master nack ends the read stream
	always @(posedge scl) begin
		if (bit_n == 8 && rd && byte_n > 0 && sda)
			rd = 1'b0;
		sh = {sh[6:0], sda};
	end
	// read data msb first, else pull low in the ninth slot unless told to refuse
	always @(negedge scl) begin
		if (bit_n == 8) begin
			bit_n = 0;
			byte_n++;
		end else begin
			bit_n++;
		end
		if (bit_n == 8 && byte_n == 0)
			rd = sh[0];
		if (rd && byte_n > 0)
			sda_pull = (bit_n < 8) && !STORED[7 - bit_n];
		else
			sda_pull = (bit_n == 8) && !nack_all;
	end
endmodule : smm_mem_model

// file: smm_serial_memory_master_tb_top.sv
// bench: table of spi and i2c transfers, each with a start repeated while busy, then a mid-run reset and row 0 again.
// assumes smm_mem_model on the pins and pull-ups on both i2c wires
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end

module smm_serial_memory_master_tb_top;
	logic clk = 0, rst = 1, link_clk = 0, start = 0, tx_valid = 0, nack_all = 0;
	logic [7:0] tx_data = 8'h00, rx_data_q;
	logic busy_q, done_q, nack_q, tx_ready_q, rx_valid_q, sclk, mosi, miso, pull;
	logic scl_o, scl_oe, sda_o, sda_oe;
	logic [1:0] spi_cs_q;
	smm_pkg::smm_req_s req = '0, rq[7];
	wire scl = scl_oe ? scl_o : 1'b1;  // pull-up when released
	wire sda = ~(sda_oe | pull);
	int miscompares = 0, samples_checked = 0, rx_n = 0;
	int erx[7] = '{2, 0, 0, 1, 2, 0, 0};  // read bytes expected per row
	logic [6:0] nk = 7'b1000000;           // row 6 meets a refusing memory
	always #20 clk = ~clk;
	initial begin
		#7;
		forever #16 link_clk = ~link_clk;
	end
	smm_serial_memory_master u_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
		.start(start), .req(req), .busy_q(busy_q), .done_q(done_q), .nack_q(nack_q),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready_q(tx_ready_q),
		.rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .spi_sclk_q(sclk),
		.spi_mosi_q(mosi), .spi_cs_q(spi_cs_q), .spi_miso(miso), .i2c_scl_o_q(scl_o),
		.i2c_scl_oe_q(scl_oe), .i2c_sda_i(sda), .i2c_sda_o_q(sda_o), .i2c_sda_oe_q(sda_oe));
	smm_mem_model u_mem (.sclk(sclk), .cs_n(spi_cs_q[0]), .miso(miso), .scl(scl),
		.sda(sda), .nack_all(nack_all), .sda_pull(pull));
	//////////////////////////////////////////////////////////////////
	// write stream offered whenever out of reset; read bytes checked as they come
	always @(posedge clk) begin
		tx_valid <= ~rst;
		if (tx_valid && tx_ready_q)
			tx_data <= tx_data + 8'h01;
		if (rx_valid_q === 1'b1) begin
			rx_n++;
			`CHK(rx_data_q, 8'hA5)
		end
	end
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	// one transfer; a second start while busy must be ignored
	task automatic run_one(input int i);
		int n;
		n = 0;
		rx_n = 0;
		@(posedge clk);
		req <= rq[i];
		nack_all <= nk[i];
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (9) @(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		while (done_q !== 1'b1 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40000) begin
			miscompares++;
			stop_test();
		end
		`CHK(nack_q, nk[i])
		`CHK(rx_n, erx[i])
		if (!rq[i].i2c_mode)
			`CHK(spi_cs_q, ~rq[i].cs_pol)
		repeat (3) @(negedge clk);
		`CHK(busy_q, 1'b0)
		$display("test %0d done", i);
	endtask : run_one
	initial begin
		for (int i = 0; i < 7; i++) begin
			rq[i] = '0;
			rq[i].cs_pol = 2'b10;
			rq[i].spi_div = 8'h05;
			rq[i].command_code_top_bit = 3'h7;
			rq[i].address_top_bit = 5'h07;
			rq[i].has_addr = (i != 2);
			rq[i].cmd = 8'h03;
			rq[i].byte_cnt = 16'h0002;
			rq[i].i2c_mode = (i > 3);
			rq[i].rw_read = (i == 0 || i == 3 || i == 4);
			rq[i].i2c_fast = (i != 5);
			rq[i].slave_id_bits = 7'h50;
		end
		rq[1] = '{default: '0, cs_sel: 1'b1, cpol: 1'b1, cpha: 1'b1, lsb_first: 1'b1,
			cs_pol: 2'b10, command_code_top_bit: 3'h7, has_addr: 1'b1,
			address_top_bit: 5'h0F, cmd: 8'h02, spi_div: 8'h05, byte_cnt: 16'h0003};
		rq[3].command_code_top_bit = 3'h3;
		rq[3].address_top_bit = 5'h0B;
		rq[3].byte_cnt = 16'h0001;
		rq[4].scl_push_pull = 1'b1;
		rq[5].byte_cnt = 16'h0000;
		repeat (4) @(posedge clk);
		@(negedge clk);
		`CHK({busy_q, done_q, nack_q, tx_ready_q, rx_valid_q, spi_cs_q, sclk, mosi, scl_oe, sda_oe, sda_o, scl_o}, 13'b0001011000000)
		@(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 7; i++)
			run_one(i);
		// reset in mid-read must drop the selects and recover
		@(posedge clk);
		req <= rq[0];
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (150) @(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK({busy_q, spi_cs_q}, 3'b011)
		repeat (5) @(posedge clk);
		run_one(0);
		stop_test();
	end
endmodule : smm_serial_memory_master_tb_top
